// >>> flags_pkg.sv
// shared constants and carrier types for the status word and address generator
// assumes a single core clock; all users qualify names with flags_pkg::
package flags_pkg;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int PSW_W = 16;
    localparam int CARRY_BIT = 0;
    localparam int PARITY_BIT = 2;
    localparam int HALF_BIT = 4;
    localparam int ZERO_BIT = 6;
    localparam int SIGN_BIT = 7;
    localparam int STEP_BIT = 8;
    localparam int INTEN_BIT = 9;
    localparam int DIR_BIT = 10;
    localparam int OVF_BIT = 11;
    localparam logic [15:0] PSW_IMPL_MASK = 16'h0fd5;
    localparam logic [15:0] PSW_RSVD_VAL = 16'h0000;
    localparam logic [15:0] PSW_RESET = 16'h0000;

    // ------------------------------------------------------------
    // segments and address forming
    // ------------------------------------------------------------
    localparam int SEG_COUNT = 4;
    localparam logic [1:0] SEG_CODE = 2'h0;
    localparam logic [1:0] SEG_DATA = 2'h1;
    localparam logic [1:0] SEG_STACK = 2'h2;
    localparam logic [1:0] SEG_EXTRA = 2'h3;
    localparam logic [15:0] SEG_RESET = 16'h0000;
    localparam int SEG_SHIFT = 4;
    localparam int PHYS_W = 20;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;

    typedef enum logic [2:0] {OP_ADD, OP_ADC, OP_SUB, OP_SBB, OP_AND, OP_OR, OP_XOR} alu_op_t;
    typedef enum logic [2:0] {
        FC_NONE, FC_SET_CARRY, FC_CLR_CARRY, FC_CMC, FC_SET_DIR, FC_CLR_DIR, FC_SET_INT, FC_CLR_INT
    } flag_cmd_t;
    typedef enum logic [2:0] {ACC_PREFETCH, ACC_IMMEDIATE, ACC_STACK, ACC_DATA, ACC_STRING_DST} acc_kind_t;

    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic word;
        logic [15:0] a;
        logic [15:0] b;
    } alu_req_t;

    typedef struct packed {
        logic valid;
        acc_kind_t kind;
        logic base_bp;
        logic ovr_valid;
        logic [1:0] ovr_seg;
        logic [15:0] offset;
    } addr_req_t;

endpackage : flags_pkg

// >>> segment_addr_gen.sv
// segment base registers and 20-bit physical address forming
// assumes requests and segment writes come from logic on the same clock
`timescale 1ns/100ps
module segment_addr_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // segment register writes
    input wire logic seg_wr,
    input wire logic [1:0] seg_sel,
    input wire logic [15:0] seg_wdata,
    // address request and answer
    input wire flags_pkg::addr_req_t addr_req,
    output logic [19:0] phys_addr,
    output logic [1:0] seg_used,
    output logic addr_valid
);

    typedef struct packed {
        logic [3:0][15:0] seg;
        logic [19:0] phys;
        logic [1:0] used;
        logic valid;
    } agen_state_t;

    agen_state_t st_r;
    agen_state_t st_nxt;

    // implied segment, replaced by a prefix only where one may apply
    function automatic logic [1:0] pick_seg(input flags_pkg::addr_req_t r);
        logic [1:0] s;
        s = flags_pkg::SEG_DATA;
        case (r.kind)
            flags_pkg::ACC_PREFETCH: s = flags_pkg::SEG_CODE; // RQ16
            flags_pkg::ACC_IMMEDIATE: s = flags_pkg::SEG_CODE; // RQ16
            flags_pkg::ACC_STACK: s = flags_pkg::SEG_STACK; // RQ17
            flags_pkg::ACC_STRING_DST: s = flags_pkg::SEG_EXTRA;
            flags_pkg::ACC_DATA: begin
                s = r.base_bp ? flags_pkg::SEG_STACK : flags_pkg::SEG_DATA; // RQ14 RQ17
                if (r.ovr_valid) begin
                    s = r.ovr_seg; // RQ15
                end
            end
            default: s = flags_pkg::SEG_DATA;
        endcase
        return s;
    endfunction : pick_seg

    always_comb begin
        logic [1:0] s;
        s = pick_seg(addr_req);
        st_nxt = st_r;
        for (int i = 0; i < flags_pkg::SEG_COUNT; i++) begin
            if (seg_wr && seg_sel == 2'(i)) begin
                st_nxt.seg[i] = seg_wdata; // RQ13
            end
        end
        st_nxt.valid = addr_req.valid;
        if (addr_req.valid) begin
            st_nxt.used = s;
            // offset is 16 bits, so a segment never spans more than 64k bytes
            st_nxt.phys = {st_r.seg[s], 4'h0} + {4'h0, addr_req.offset}; // RQ11 RQ12
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '{seg: {4{flags_pkg::SEG_RESET}}, phys: 20'h00000, used: 2'h0, valid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign phys_addr = st_r.phys;
    assign seg_used = st_r.used;
    assign addr_valid = st_r.valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_phys_addr_sum: assert property (addr_req.valid && !seg_wr |=> // RQ11
        phys_addr == 20'(({4'h0, st_r.seg[seg_used]} << 4) + $past(addr_req.offset)))
        else $error("physical address not base times 16 plus offset");
    a_override_used: assert property (addr_req.valid && addr_req.kind == flags_pkg::ACC_DATA // RQ15
        && addr_req.ovr_valid |=> seg_used == $past(addr_req.ovr_seg))
        else $error("override segment not used");
    a_stack_segment: assert property (addr_req.valid && addr_req.kind == flags_pkg::ACC_STACK // RQ17
        |=> seg_used == flags_pkg::SEG_STACK)
        else $error("stack access not on stack segment");

endmodule : segment_addr_gen

// >>> status_flags_and_address_gen.sv
// status word, result flags, step and interrupt gating, string step and address forming
// assumes the execution unit drives all requests on the core clock, one at a time
//
// How it works
// RQ1: carry set on carry out of or borrow into the top result bit.
// RQ2: parity set when low result byte holds an even count of ones.
// RQ3: half-carry set on carry or borrow across bit 3 of the low byte.
// RQ4: zero flag set when result equals zero, cleared otherwise.
// RQ5: sign flag copies the result's top bit.
// RQ6: with step flag set, trap after the next instruction; trap clears the flag.
// RQ7: interrupt-enable flag set lets maskable requests in; clear ignores them.
// RQ8: direction flag set makes string steps decrement, clear makes them increment.
// RQ9: overflow set when signed result does not fit destination width.
// RQ10: status word is one 16-bit register holding result and control flags.
// RQ11: physical address is segment base shifted left four plus offset, 20 bits.
// RQ12: each segment spans at most 64k bytes through a 16-bit offset.
// RQ13: four 16-bit segment base registers supply every segment base.
// RQ14: without override, segment follows from the addressing mode.
// RQ15: an override prefix replaces the implied segment. (The code applies it to ACC_DATA requests only.)
// RQ16: code segment serves prefetches and immediate fetches.
// RQ17: stack segment serves pushes, pops and base-pointer based references.
// RQ18: unassigned status bits read a fixed value and ignore results.
`timescale 1ns/100ps
module status_flags_and_address_gen (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // arithmetic result request
    input wire flags_pkg::alu_req_t alu_req,
    output logic [15:0] alu_result,
    // status word access
    input wire logic psw_wr,
    input wire logic [15:0] psw_wdata,
    input wire flags_pkg::flag_cmd_t flag_cmd,
    output logic [15:0] psw_rdata,
    // instruction boundary, traps and interrupts
    input wire logic instr_done,
    input wire logic irq_req,
    output logic step_trap,
    output logic irq_take,
    // string index stepping
    input wire logic str_req,
    input wire logic str_word,
    output logic [15:0] str_delta,
    // segment registers and addressing
    input wire logic seg_wr,
    input wire logic [1:0] seg_sel,
    input wire logic [15:0] seg_wdata,
    input wire flags_pkg::addr_req_t addr_req,
    output logic [19:0] phys_addr,
    output logic [1:0] seg_used,
    output logic addr_valid
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] psw;
        logic [15:0] result;
        logic tf_armed;
        logic step_trap;
        logic irq_take;
        logic [15:0] str_delta;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;

    function automatic logic top_bit(input logic [15:0] v, input logic word);
        return word ? v[15] : v[7];
    endfunction : top_bit

    // ------------------------------------------------------------
    // flag evaluation and status word update
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] a;
        logic [15:0] b;
        logic [16:0] sum;
        logic [15:0] res;
        logic cin;
        logic cy;
        logic half;
        logic ovf;
        logic arith;
        logic is_sub;
        logic ma;
        logic mb;
        logic mr;
        logic [15:0] psw;
        a = alu_req.word ? alu_req.a : {8'h00, alu_req.a[7:0]};
        b = alu_req.word ? alu_req.b : {8'h00, alu_req.b[7:0]};
        cin = (alu_req.op == flags_pkg::OP_ADC || alu_req.op == flags_pkg::OP_SBB)
            && st_r.psw[flags_pkg::CARRY_BIT];
        is_sub = (alu_req.op == flags_pkg::OP_SUB || alu_req.op == flags_pkg::OP_SBB);
        arith = 1'b1;
        sum = 17'h00000;
        case (alu_req.op)
            flags_pkg::OP_ADD, flags_pkg::OP_ADC: sum = {1'b0, a} + {1'b0, b} + {16'h0000, cin};
            flags_pkg::OP_SUB, flags_pkg::OP_SBB: sum = {1'b0, a} - {1'b0, b} - {16'h0000, cin};
            flags_pkg::OP_AND: begin
                sum = {1'b0, a & b};
                arith = 1'b0;
            end
            flags_pkg::OP_OR: begin
                sum = {1'b0, a | b};
                arith = 1'b0;
            end
            flags_pkg::OP_XOR: begin
                sum = {1'b0, a ^ b};
                arith = 1'b0;
            end
            default: arith = 1'b0;
        endcase
        res = alu_req.word ? sum[15:0] : {8'h00, sum[7:0]};
        // a byte borrow also lands in bit 8 since both operands are below 256
        cy = arith && (alu_req.word ? sum[16] : sum[8]); // RQ1
        half = arith && (a[4] ^ b[4] ^ res[4]); // RQ3
        ma = top_bit(a, alu_req.word);
        mb = top_bit(b, alu_req.word);
        mr = top_bit(res, alu_req.word);
        ovf = arith && (is_sub ? (ma != mb) : (ma == mb)) && (mr != ma); // RQ9

        st_nxt = st_r;
        st_nxt.step_trap = 1'b0;
        st_nxt.irq_take = 1'b0;
        psw = st_r.psw;

        if (psw_wr) begin
            psw = psw_wdata; // RQ10
        end else if (alu_req.valid) begin
            psw[flags_pkg::CARRY_BIT] = cy; // RQ1
            psw[flags_pkg::PARITY_BIT] = ~^res[7:0]; // RQ2
            psw[flags_pkg::HALF_BIT] = half; // RQ3
            psw[flags_pkg::ZERO_BIT] = (res == 16'h0000); // RQ4
            psw[flags_pkg::SIGN_BIT] = mr; // RQ5
            psw[flags_pkg::OVF_BIT] = ovf; // RQ9
            st_nxt.result = res;
        end else begin
            case (flag_cmd)
                flags_pkg::FC_SET_CARRY: psw[flags_pkg::CARRY_BIT] = 1'b1;
                flags_pkg::FC_CLR_CARRY: psw[flags_pkg::CARRY_BIT] = 1'b0;
                flags_pkg::FC_CMC: psw[flags_pkg::CARRY_BIT] = ~st_r.psw[flags_pkg::CARRY_BIT];
                flags_pkg::FC_SET_DIR: psw[flags_pkg::DIR_BIT] = 1'b1;
                flags_pkg::FC_CLR_DIR: psw[flags_pkg::DIR_BIT] = 1'b0;
                flags_pkg::FC_SET_INT: psw[flags_pkg::INTEN_BIT] = 1'b1;
                flags_pkg::FC_CLR_INT: psw[flags_pkg::INTEN_BIT] = 1'b0;
                default: psw = st_r.psw;
            endcase
        end

        // step flag set during an instruction traps only after the one that follows
        if (instr_done) begin
            if (st_r.tf_armed) begin
                st_nxt.step_trap = 1'b1; // RQ6
                psw[flags_pkg::STEP_BIT] = 1'b0; // RQ6
                st_nxt.tf_armed = 1'b0;
            end else if (irq_req && st_r.psw[flags_pkg::INTEN_BIT]) begin
                // entering the handler masks further requests and stepping
                st_nxt.irq_take = 1'b1; // RQ7
                psw[flags_pkg::INTEN_BIT] = 1'b0;
                psw[flags_pkg::STEP_BIT] = 1'b0;
                st_nxt.tf_armed = 1'b0;
            end else begin
                st_nxt.tf_armed = st_r.psw[flags_pkg::STEP_BIT]; // RQ6
            end
        end

        st_nxt.psw = (psw & flags_pkg::PSW_IMPL_MASK) | flags_pkg::PSW_RSVD_VAL; // RQ18

        if (str_req) begin
            st_nxt.str_delta = str_word ? flags_pkg::STEP_WORD : flags_pkg::STEP_BYTE;
            if (st_r.psw[flags_pkg::DIR_BIT]) begin
                st_nxt.str_delta = 16'h0000 - st_nxt.str_delta; // RQ8
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '{psw: flags_pkg::PSW_RESET, result: 16'h0000, tf_armed: 1'b0, step_trap: 1'b0,
                      irq_take: 1'b0, str_delta: 16'h0000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign psw_rdata = st_r.psw;
    assign alu_result = st_r.result;
    assign step_trap = st_r.step_trap;
    assign irq_take = st_r.irq_take;
    assign str_delta = st_r.str_delta;

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    segment_addr_gen u_agen (
        .clk(clk),
        .rst_b(rst_b),
        .seg_wr(seg_wr),
        .seg_sel(seg_sel),
        .seg_wdata(seg_wdata),
        .addr_req(addr_req),
        .phys_addr(phys_addr),
        .seg_used(seg_used),
        .addr_valid(addr_valid)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_carry_word_add: assert property (!psw_wr && alu_req.valid && alu_req.op == flags_pkg::OP_ADD // RQ1
        && alu_req.word |=> psw_rdata[0] == ($past({1'b0, alu_req.a}) + $past({1'b0, alu_req.b}) > 17'h0ffff))
        else $error("carry wrong after word add");
    a_parity_even: assert property (!psw_wr && alu_req.valid |=> psw_rdata[2] == ~^alu_result[7:0]) // RQ2
        else $error("parity flag disagrees with result");
    a_half_carry_add: assert property (!psw_wr && alu_req.valid && alu_req.op == flags_pkg::OP_ADD // RQ3
        |=> psw_rdata[4] == ({1'b0, $past(alu_req.a[3:0])} + {1'b0, $past(alu_req.b[3:0])} > 5'h0f))
        else $error("half carry wrong after add");
    a_zero_result: assert property (!psw_wr && alu_req.valid |=> psw_rdata[6] == (alu_result == 16'h0000)) // RQ4
        else $error("zero flag disagrees with result");
    a_sign_word: assert property (!psw_wr && alu_req.valid && alu_req.word |=> psw_rdata[7] == alu_result[15]) // RQ5
        else $error("sign flag not result top bit");
    a_step_trap: assert property (instr_done && st_r.tf_armed |=> step_trap && !irq_take && !psw_rdata[8]) // RQ6
        else $error("armed step flag did not trap at the boundary");
    a_step_clears: assert property ($rose(step_trap) |-> !psw_rdata[8] && $past(instr_done)) // RQ6
        else $error("step trap without clearing step flag");
    a_irq_masked: assert property (instr_done && !psw_rdata[9] |=> !irq_take) // RQ7
        else $error("maskable request taken while disabled");
    a_irq_taken: assert property (instr_done && irq_req && psw_rdata[9] && !st_r.tf_armed |=> irq_take) // RQ7
        else $error("enabled request not taken");
    a_dir_decrement: assert property (str_req && psw_rdata[10] |=> str_delta[15]) // RQ8
        else $error("string step not decrementing");
    a_ovf_word_add: assert property (!psw_wr && alu_req.valid && alu_req.op == flags_pkg::OP_ADD && alu_req.word // RQ9
        |=> psw_rdata[11] == ($past(alu_req.a[15]) == $past(alu_req.b[15]) && alu_result[15] != $past(alu_req.a[15])))
        else $error("overflow wrong after word add");
    a_reserved_fixed: assert property ((psw_rdata & ~flags_pkg::PSW_IMPL_MASK) == flags_pkg::PSW_RSVD_VAL) // RQ18
        else $error("reserved status bits not fixed");

endmodule : status_flags_and_address_gen

// >>> tb_top.sv
// self-checking bench for the status word, string step and segment address forming
// assumes flags_pkg is compiled first; the design's own assertions run alongside
`timescale 1ns/100ps
module tb_top;
    typedef struct {
        flags_pkg::alu_op_t op;
        logic word;
        logic [15:0] a, b, res, psw;
    } alu_row_t;
    typedef struct {
        flags_pkg::acc_kind_t kind;
        logic bp, ov;
        logic [1:0] os;
        logic [15:0] off;
        logic [1:0] seg;
        logic [19:0] phys;
    } addr_row_t;

    logic clk, rst_b, psw_wr, instr_done, irq_req, str_req, str_word, seg_wr;
    logic [15:0] psw_wdata, seg_wdata, alu_result, psw_rdata, str_delta;
    logic [1:0] seg_sel, seg_used;
    logic [19:0] phys_addr;
    logic step_trap, irq_take, addr_valid;
    flags_pkg::alu_req_t alu_req;
    flags_pkg::addr_req_t addr_req;
    flags_pkg::flag_cmd_t flag_cmd;
    int err_count, checked;

    // rows chain: adc and sbb lean on the carry left by the row above
    alu_row_t alu_rows [10] = '{
        '{flags_pkg::OP_ADD, 1'b1, 16'hffff, 16'h0001, 16'h0000, 16'h0055},
        '{flags_pkg::OP_ADC, 1'b1, 16'h0001, 16'h0001, 16'h0003, 16'h0004},
        '{flags_pkg::OP_SUB, 1'b0, 16'h0000, 16'h0001, 16'h00ff, 16'h0095},
        '{flags_pkg::OP_SBB, 1'b0, 16'h0080, 16'h0000, 16'h007f, 16'h0810},
        '{flags_pkg::OP_ADD, 1'b0, 16'h127f, 16'h3401, 16'h0080, 16'h0890},
        '{flags_pkg::OP_AND, 1'b1, 16'hff00, 16'h0f0f, 16'h0f00, 16'h0004},
        '{flags_pkg::OP_OR, 1'b1, 16'h8000, 16'h0001, 16'h8001, 16'h0080},
        '{flags_pkg::OP_XOR, 1'b1, 16'h1234, 16'h1234, 16'h0000, 16'h0044},
        '{flags_pkg::OP_ADD, 1'b1, 16'h8000, 16'h8000, 16'h0000, 16'h0845},
        '{flags_pkg::OP_SUB, 1'b1, 16'h0000, 16'h8000, 16'h8000, 16'h0885}};
    flags_pkg::flag_cmd_t fc_rows [8] = '{flags_pkg::FC_CLR_CARRY, flags_pkg::FC_SET_CARRY, flags_pkg::FC_CMC,
        flags_pkg::FC_SET_DIR, flags_pkg::FC_CLR_DIR, flags_pkg::FC_SET_INT, flags_pkg::FC_CLR_INT, flags_pkg::FC_NONE};
    logic [15:0] fc_exp [8] = '{16'h0884, 16'h0885, 16'h0884, 16'h0c84, 16'h0884, 16'h0a84, 16'h0884, 16'h0884};
    logic [15:0] seg_vals [4] = '{16'h1000, 16'h2345, 16'hfff0, 16'h4000};
    addr_row_t addr_rows [8] = '{
        '{flags_pkg::ACC_PREFETCH, 1'b0, 1'b0, 2'h0, 16'h0010, 2'h0, 20'h10010},
        '{flags_pkg::ACC_IMMEDIATE, 1'b0, 1'b1, 2'h3, 16'hffff, 2'h0, 20'h1ffff},
        '{flags_pkg::ACC_STACK, 1'b0, 1'b0, 2'h0, 16'h0200, 2'h2, 20'h00100},
        '{flags_pkg::ACC_DATA, 1'b1, 1'b0, 2'h0, 16'h0004, 2'h2, 20'hfff04},
        '{flags_pkg::ACC_DATA, 1'b0, 1'b0, 2'h0, 16'hffff, 2'h1, 20'h3344f},
        '{flags_pkg::ACC_DATA, 1'b0, 1'b1, 2'h3, 16'h0001, 2'h3, 20'h40001},
        '{flags_pkg::ACC_DATA, 1'b1, 1'b1, 2'h0, 16'h0002, 2'h0, 20'h10002},
        '{flags_pkg::ACC_STRING_DST, 1'b0, 1'b1, 2'h1, 16'h0008, 2'h3, 20'h40008}};
    logic [15:0] exp_delta;

    status_flags_and_address_gen u_status_flags_and_address_gen (
        .clk(clk), .rst_b(rst_b), .alu_req(alu_req), .alu_result(alu_result),
        .psw_wr(psw_wr), .psw_wdata(psw_wdata), .flag_cmd(flag_cmd), .psw_rdata(psw_rdata),
        .instr_done(instr_done), .irq_req(irq_req), .step_trap(step_trap), .irq_take(irq_take),
        .str_req(str_req), .str_word(str_word), .str_delta(str_delta),
        .seg_wr(seg_wr), .seg_sel(seg_sel), .seg_wdata(seg_wdata), .addr_req(addr_req),
        .phys_addr(phys_addr), .seg_used(seg_used), .addr_valid(addr_valid));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // each request is held for one edge, answer sampled just after the next
    task automatic fcmd(input flags_pkg::flag_cmd_t c);
        @(posedge clk) flag_cmd <= c;
        @(posedge clk) flag_cmd <= flags_pkg::FC_NONE;
        #1;
    endtask : fcmd

    task automatic boundary;
        @(posedge clk) instr_done <= 1'b1;
        @(posedge clk) instr_done <= 1'b0;
        #1;
    endtask : boundary

    task automatic addr(input addr_row_t r);
        @(posedge clk) addr_req <= '{1'b1, r.kind, r.bp, r.ov, r.os, r.off};
        @(posedge clk) addr_req.valid <= 1'b0;
        #1;
        chk(20'(seg_used), 20'(r.seg));
        chk(phys_addr, r.phys);
        chk(20'(addr_valid), 20'h1);
    endtask : addr

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        {psw_wr, instr_done, irq_req, str_req, str_word, seg_wr} = '0;
        {psw_wdata, seg_wdata, seg_sel} = '0;
        alu_req = '0;
        addr_req = '0;
        flag_cmd = flags_pkg::FC_NONE;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk(20'(psw_rdata), 20'(flags_pkg::PSW_RESET));
        foreach (alu_rows[i]) begin
            @(posedge clk) alu_req <= '{1'b1, alu_rows[i].op, alu_rows[i].word, alu_rows[i].a, alu_rows[i].b};
            @(posedge clk) alu_req.valid <= 1'b0;
            #1;
            chk(20'(alu_result), 20'(alu_rows[i].res));
            chk(20'(psw_rdata), 20'(alu_rows[i].psw));
        end
        foreach (fc_rows[i]) begin
            fcmd(fc_rows[i]);
            chk(20'(psw_rdata), 20'(fc_exp[i]));
        end
        // status write beats a same-cycle add; unassigned bits stay fixed
        @(posedge clk) begin
            psw_wr <= 1'b1;
            psw_wdata <= 16'hffff;
            alu_req <= '{1'b1, flags_pkg::OP_ADD, 1'b1, 16'h0000, 16'h0000};
        end
        @(posedge clk) begin
            psw_wr <= 1'b0;
            alu_req.valid <= 1'b0;
            psw_wdata <= 16'h0100;
        end
        #1;
        chk(20'(psw_rdata), 20'(flags_pkg::PSW_IMPL_MASK));
        @(posedge clk) psw_wr <= 1'b1;
        @(posedge clk) psw_wr <= 1'b0;
        irq_req <= 1'b1;
        #1;
        chk(20'(psw_rdata), 20'h00100);
        boundary();
        chk(20'({step_trap, irq_take}), 20'h0);
        // armed step trap beats an enabled request at the same boundary
        fcmd(flags_pkg::FC_SET_INT);
        boundary();
        chk(20'({step_trap, irq_take}), 20'h2);
        chk(20'(psw_rdata), 20'h00200);
        @(posedge clk);
        #1;
        chk(20'(step_trap), 20'h0);
        fcmd(flags_pkg::FC_SET_INT);
        boundary();
        chk(20'(irq_take), 20'h1);
        chk(20'(psw_rdata), 20'h0);
        irq_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            fcmd(i[1] ? flags_pkg::FC_SET_DIR : flags_pkg::FC_CLR_DIR);
            @(posedge clk) begin
                str_req <= 1'b1;
                str_word <= i[0];
            end
            @(posedge clk) str_req <= 1'b0;
            #1;
            exp_delta = i[0] ? flags_pkg::STEP_WORD : flags_pkg::STEP_BYTE;
            if (i[1]) begin
                exp_delta = -exp_delta;
            end
            chk(20'(str_delta), 20'(exp_delta));
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk) begin
                seg_wr <= 1'b1;
                seg_sel <= 2'(s);
                seg_wdata <= seg_vals[s];
            end
            @(posedge clk) seg_wr <= 1'b0;
        end
        foreach (addr_rows[i]) begin
            addr(addr_rows[i]);
        end
        // a segment write racing a request: the request still sees the old base
        @(posedge clk) begin
            seg_wr <= 1'b1;
            seg_sel <= flags_pkg::SEG_DATA;
            seg_wdata <= 16'h5000;
            addr_req <= '{1'b1, flags_pkg::ACC_DATA, 1'b0, 1'b0, 2'h0, 16'h0000};
        end
        @(posedge clk) begin
            seg_wr <= 1'b0;
            addr_req.valid <= 1'b0;
        end
        #1;
        chk(phys_addr, 20'h23450);
        addr('{flags_pkg::ACC_DATA, 1'b0, 1'b0, 2'h0, 16'h0000, 2'h1, 20'h50000});
        @(posedge clk);
        #1;
        chk(20'(addr_valid), 20'h0);
        // reset in mid-run clears everything, segment bases included
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(20'(psw_rdata), 20'h0);
        chk(20'(alu_result), 20'h0);
        chk(20'(str_delta), 20'h0);
        chk(phys_addr, 20'h0);
        chk(20'({seg_used, step_trap, irq_take, addr_valid}), 20'h0);
        @(posedge clk) rst_b <= 1'b1;
        addr('{flags_pkg::ACC_DATA, 1'b0, 1'b0, 2'h0, 16'h0010, 2'h1, 20'h00010});
        end_of_test();
    end
endmodule : tb_top
